/* tb/atab_top_assertions.sv */
/*
  Checker for atab_top: APB handshake, error answer, reserved bits
  that read zero, learn acceptance. Sees only the top module's ports.
*/
`timescale 1ns/10ps
`include "atab_regs.vh"
module atab_chk #(
  parameter BIN_AW = 4
) (
  input wire                   mclk_in,
  input wire                   rst_b_in,
  input wire                   psel_in,
  input wire                   penable_in,
  input wire                   pwrite_in,
  input wire [7:0]             paddr_in,
  input wire [31:0]            pwdata_in,
  input wire                   pready_out,
  input wire [31:0]            prdata_out,
  input wire                   pslverr_out,
  input wire                   learn_req_in,
  input wire [BIN_AW-1:0]      learn_bin_in,
  input wire [`ATAB_MAC_W-1:0] learn_mac_in,
  input wire [`ATAB_VID_W-1:0] learn_vid_in,
  input wire [4:0]             learn_port_in,
  input wire                   learn_ready_out
);
  // Decoded offsets; anything else must be refused
  wire mapped = paddr_in inside {8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28, 8'h2c,
                                 8'h30, 8'h40, 8'h44, 8'h50, 8'h54, 8'h58, 8'h60,
                                 8'h64, 8'h68};
  wire rd_done = pready_out && !pwrite_in;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_ready_after_access: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("pready missing after access cycle");
  a_ready_one_cycle: assert property (pready_out |=> !pready_out)
    else $error("pready held over two cycles");
  a_ready_has_request: assert property (pready_out |-> psel_in && $past(penable_in))
    else $error("pready without access phase");
  a_err_unmapped: assert property (pready_out && !mapped |-> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped offset not refused");
  a_err_only_unmapped: assert property (pready_out && mapped |-> !pslverr_out)
    else $error("error on mapped offset");
  a_ctl_reserved_zero: assert property (rd_done && paddr_in == 8'h30 |->
    prdata_out[31:8] == 24'h0 && prdata_out[6:1] == 6'h0)
    else $error("walk control reserved bits set");
  a_fwd_reserved_zero: assert property (rd_done && paddr_in == 8'h28 |->
    prdata_out[31:22] == 10'h0)
    else $error("forwarding reserved bits set");
  a_vid_word_reserved: assert property (rd_done && paddr_in == 8'h24 |->
    prdata_out[31:28] == 4'h0)
    else $error("vlan word reserved bits set");
  a_write_reads_zero: assert property (pready_out && pwrite_in |-> prdata_out == 32'h0)
    else $error("read data on write");
  a_learn_taken: assert property (learn_req_in && learn_ready_out |=> !learn_ready_out)
    else $error("learn request not taken");

  // Main scenarios reached
  c_refused: cover property (pready_out && pslverr_out);
  c_walk_hit: cover property (rd_done && paddr_in == 8'h30 && prdata_out[0]);
  c_learn: cover property (learn_req_in && learn_ready_out);
endmodule

bind atab_top atab_chk #(.BIN_AW(BIN_AW)) atab_chk_i (
  .mclk_in(mclk_in), .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
  .learn_req_in(learn_req_in), .learn_bin_in(learn_bin_in), .learn_mac_in(learn_mac_in),
  .learn_vid_in(learn_vid_in), .learn_port_in(learn_port_in),
  .learn_ready_out(learn_ready_out));

/* tb/atab_top_test.sv */
/*
  Self-checking bench for atab_top: registers, decode, refusal,
  indexed table access, walk, aging and learning over APB.
  Assumes the design and checker files are compiled first.
*/
`timescale 1ns/10ps
module atab_top_test;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        perr;
  logic        lreq = 1'b0;
  logic        lrdy;
  logic [1:0]  lbin = 2'h0;
  logic [47:0] lmac = 48'h0;
  logic [11:0] lvid = 12'h0;
  logic [4:0]  lport = 5'h0;
  logic [31:0] q;
  logic        e;
  int          n_fail = 0;
  int          n_compared = 0;

  // Small table and short aging period keep the run brief
  atab_top #(.BIN_AW(2), .AGE_PERIOD_CYCLES(200)) atab_top_i (
    .mclk_in(clk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
    .pslverr_out(perr), .learn_req_in(lreq), .learn_bin_in(lbin), .learn_mac_in(lmac),
    .learn_vid_in(lvid), .learn_port_in(lport), .learn_ready_out(lrdy));

  initial forever #5 clk = ~clk;

  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask

  // One APB transfer; pready sampled at the rising edge, released after it
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      finish_test;
    end
    q = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, x, q & m);
  endtask

  // Bounded poll until the masked value appears
  task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    int k;
    k = 0;
    do begin
      apb(1'b0, a, 32'h0);
      k++;
    end while ((q & m) !== x && k < 300);
    chk("poll", x, q & m);
  endtask

  task put(input logic [1:0] b, input logic [31:0] al, ah, af, bl, bh, bf);
    apb(1'b1, 8'h10, al);
    apb(1'b1, 8'h14, ah);
    apb(1'b1, 8'h18, af);
    apb(1'b1, 8'h20, bl);
    apb(1'b1, 8'h24, bh);
    apb(1'b1, 8'h28, bf);
    apb(1'b1, 8'h40, {30'h0, b});
    apb(1'b1, 8'h44, 32'h2);
    poll(8'h44, 32'h3, 32'h0);
  endtask

  task get(input logic [1:0] b);
    apb(1'b1, 8'h40, {30'h0, b});
    apb(1'b1, 8'h44, 32'h1);
    poll(8'h44, 32'h3, 32'h0);
  endtask

  task t_regs;
    rdc("b_lo_rst", 8'h20, 32'hffffffff, 32'h0);
    rdc("b_fwd_rst", 8'h28, 32'hffffffff, 32'h0);
    rdc("ctl_rst", 8'h30, 32'hffffffff, 32'h0);
    apb(1'b1, 8'h20, 32'hffffffff);
    apb(1'b1, 8'h24, 32'hffffffff);
    apb(1'b1, 8'h28, 32'hffffffff);
    apb(1'b1, 8'h30, 32'h7f);
    rdc("b_lo", 8'h20, 32'hffffffff, 32'hffffffff);
    rdc("b_hi", 8'h24, 32'hffffffff, 32'h0fffffff);
    rdc("b_fwd", 8'h28, 32'hffffffff, 32'h003fffff);
    rdc("ctl", 8'h30, 32'hffffffff, 32'h0);
  endtask

  // Portmap is forwarding bits 21:5 in order
  task t_decode;
    apb(1'b1, 8'h24, 32'h8000);
    apb(1'b1, 8'h28, 32'h2aaaa0);
    rdc("mcast", 8'h2c, 32'h8001ffff, 32'h80000000 | (32'h2aaaa0 >> 5));
    apb(1'b1, 8'h24, 32'h0);
    apb(1'b1, 8'h28, 32'h560);
    rdc("ucast", 8'h2c, 32'h8002001f, 32'h00020015);
  endtask

  task t_unmapped;
    apb(1'b1, 8'h7c, 32'h12345678);
    chk("wr_err", 32'h1, {31'h0, e});
    rdc("rd_data", 8'h7c, 32'hffffffff, 32'h0);
    chk("rd_err", 32'h1, {31'h0, e});
  endtask

  task t_walk;
    put(2'd1, 32'h12345678, 32'h0abc00de, 32'h268, 32'hbbb, 32'h0, 32'h0);
    put(2'd3, 32'h0, 32'h0, 32'h0, 32'h87654321, 32'h01230042, 32'h2a8);
    get(2'd1);
    rdc("idx_a", 8'h10, 32'hffffffff, 32'h12345678);
    rdc("idx_b", 8'h20, 32'hffffffff, 32'hbbb);
    apb(1'b1, 8'h30, 32'h80);
    poll(8'h30, 32'h81, 32'h81);
    rdc("r1_vid", 8'h64, 32'hffffffff, 32'h0);
    rdc("r0_vid", 8'h54, 32'hffffffff, 32'h0abc00de);
    rdc("hit_kept", 8'h30, 32'hffffffff, 32'h81);
    rdc("r1_fwd", 8'h68, 32'hffffffff, 32'h0);
    rdc("r0_fwd", 8'h58, 32'hffffffff, 32'h268);
    rdc("r0_clr", 8'h50, 32'hffffffff, 32'h0);
    poll(8'h30, 32'h81, 32'h81);
    rdc("r1_lo", 8'h60, 32'hffffffff, 32'h87654321);
    rdc("r0_fwd2", 8'h58, 32'hffffffff, 32'h0);
    poll(8'h30, 32'hff, 32'h0);
  endtask

  // Two aging ticks: age cleared, then entry dropped
  task t_aging;
    put(2'd0, 32'habc, 32'h0, 32'h18, 32'h0, 32'h0, 32'h0);
    repeat (450) @(posedge clk);
    get(2'd0);
    rdc("aged", 8'h18, 32'h18, 32'h0);
    get(2'd1);
    rdc("static", 8'h18, 32'h28, 32'h28);
  endtask

  task t_learn;
    int n;
    n = 0;
    @(posedge clk);
    lbin <= 2'd1;
    lmac <= 48'h010203040506;
    lvid <= 12'h055;
    lport <= 5'd7;
    lreq <= 1'b1;
    // Request held until the edge at which ready is seen high
    do begin
      @(posedge clk);
      n++;
    end while (lrdy !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      finish_test;
    end
    lreq <= 1'b0;
    get(2'd1);
    rdc("lrn_lo", 8'h20, 32'hffffffff, 32'h03040506);
    rdc("lrn_hi", 8'h24, 32'hffffffff, 32'h00550102);
    rdc("lrn_fwd", 8'h28, 32'h7e8, 32'h1c8);
    rdc("static_kept", 8'h10, 32'hffffffff, 32'h12345678);
  endtask

  task finish_test;
    if (n_fail == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence; commands wait for the post-reset table clear
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (12) @(posedge clk);
    t_regs;
    t_decode;
    t_unmapped;
    t_walk;
    t_aging;
    t_learn;
    finish_test;
  end

  // Watchdog well beyond the one thousand or so cycles expected
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test;
  end
endmodule

/* verilog/atab_age_tick.v */
/*
  Aging period timer: one-cycle tick every PERIOD cycles.
  Assumes a synchronised active-low reset.
*/
`timescale 1ns/10ps
module atab_age_tick #(
  parameter PERIOD = 1000000,
  parameter CNT_W  = 32
) (
  input  wire clk_in,
  input  wire rst_b_in,
  output reg  tick_out
);
  localparam [CNT_W-1:0] LAST = PERIOD - 1;
  localparam [CNT_W-1:0] ONE  = 1;
  reg [CNT_W-1:0] cnt_reg;

  // Free-running count, wraps at the period
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_reg  <= {CNT_W{1'b0}};
      tick_out <= 1'b0;
    end else if (cnt_reg == LAST) begin
      cnt_reg  <= {CNT_W{1'b0}};
      tick_out <= 1'b1;
    end else begin
      cnt_reg  <= cnt_reg + ONE;
      tick_out <= 1'b0;
    end
  end
endmodule

/* verilog/atab_bin_store.v */
/*
  Address table storage: bins of two entries, whole-bin read,
  per-slot write. Assumes the owner clears it after reset.
*/
`timescale 1ns/10ps
module atab_bin_store #(
  parameter BIN_AW = 4,
  parameter ENT_W  = 82
) (
  input  wire              clk_in,
  input  wire [BIN_AW-1:0] rbin_in,
  output wire [ENT_W-1:0]  rd0_out,
  output wire [ENT_W-1:0]  rd1_out,
  input  wire [BIN_AW-1:0] wbin_in,
  input  wire              we0_in,
  input  wire              we1_in,
  input  wire [ENT_W-1:0]  wd0_in,
  input  wire [ENT_W-1:0]  wd1_in
);
  reg [ENT_W-1:0] slot0_mem [0:(1<<BIN_AW)-1];
  reg [ENT_W-1:0] slot1_mem [0:(1<<BIN_AW)-1];

  // Asynchronous read keeps the engine at one bin per cycle
  assign rd0_out = slot0_mem[rbin_in];
  assign rd1_out = slot1_mem[rbin_in];

  // Independent slot writes
  always @(posedge clk_in) begin
    if (we0_in) begin
      slot0_mem[wbin_in] <= wd0_in;
    end
    if (we1_in) begin
      slot1_mem[wbin_in] <= wd1_in;
    end
  end
endmodule

/* verilog/atab_regs.vh */
/*
  Register offsets, field positions and reset values of the address
  table staging and walk block. Assumes 32-bit APB, byte addresses.
*/
`ifndef ATAB_REGS_VH
`define ATAB_REGS_VH
// Register byte offsets
`define ATAB_OFF_A_MACLO 8'h10
`define ATAB_OFF_A_MACHI 8'h14
`define ATAB_OFF_A_FWD   8'h18
`define ATAB_OFF_B_MACLO 8'h20
`define ATAB_OFF_B_MACHI 8'h24
`define ATAB_OFF_B_FWD   8'h28
`define ATAB_OFF_B_DEC   8'h2c
`define ATAB_OFF_CTL     8'h30
`define ATAB_OFF_INDEX   8'h40
`define ATAB_OFF_CMD     8'h44
`define ATAB_OFF_R0_LO   8'h50
`define ATAB_OFF_R0_VID  8'h54
`define ATAB_OFF_R0_FWD  8'h58
`define ATAB_OFF_R1_LO   8'h60
`define ATAB_OFF_R1_VID  8'h64
`define ATAB_OFF_R1_FWD  8'h68
// Field widths
`define ATAB_MAC_W 48
`define ATAB_VID_W 12
`define ATAB_FWD_W 22
`define ATAB_ENT_W 82
// Packed entry {vlan id, mac, forwarding word}
`define ATAB_E_VID   81:70
`define ATAB_E_MAC   69:22
`define ATAB_E_MACHI 69:54
`define ATAB_E_MACLO 53:22
`define ATAB_E_FWD   21:0
// Forwarding word fields
`define ATAB_FWD_MAPHI  21:11
`define ATAB_FWD_PORT   10:6
`define ATAB_FWD_STATIC 5
`define ATAB_FWD_AGE    4
`define ATAB_FWD_VALID  3
`define ATAB_MCAST_BIT  47
`define ATAB_E_MCAST    69
// Upper word of the mac/vid register
`define ATAB_W_VID   27:16
`define ATAB_W_MACHI 15:0
`define ATAB_MAC_HI  47:32
`define ATAB_MAC_LO  31:0
// Decoded view of entry b
`define ATAB_DEC_MCAST  31
`define ATAB_DEC_STATIC 17
`define ATAB_DEC_MAP    16:0
`define ATAB_DEC_PORT   4:0
// Control and command bits
`define ATAB_CTL_START 7
`define ATAB_CTL_HIT   0
`define ATAB_CMD_RD    0
`define ATAB_CMD_WR    1
// Reset values
`define ATAB_RST_MAC 48'h0
`define ATAB_RST_VID 12'h0
`define ATAB_RST_FWD 22'h0
`define ATAB_RST_ENT 82'h0
`define ATAB_RST_32  32'h0
// Low forwarding bits of a learned entry: valid and age set
`define ATAB_LRN_FLAGS 6'h18
`endif

/* verilog/atab_top.v */
/*
  Address table staging registers, indexed bin access, learning,
  aging sweep and sequential table walk, behind an APB slave.
  Assumes APB master on mclk_in and a learn source on the same clock.
*/
// Chosen here: register access over APB.
// Operation
// [RULE1] Entry b holds a 12-bit VLAN ID
// [RULE2] Entry b holds a 48-bit MAC
// [RULE3] Multicast: bits 21:11 give portmap 16:6
// [RULE4] Unicast: bits 10:6 give port number
// [RULE5] Multicast: bits 10:6,5 give portmap 5:0
// [RULE6] Static entries never learned over nor aged
// [RULE7] Age set on access, aging clears then invalidates
// [RULE8] Learn only into invalid non-static slot
// [RULE9] Start bit begins walk of valid unaged entries
// [RULE10] Start bit self-clears when walk completes
// [RULE11] Hit flag set when result is staged
// [RULE12] Result read clears hit, resumes walk
// [RULE13] VLAN result read has no side effect
// [RULE14] Entry zero read clears all results
// [RULE15] Host reads entry one before entry zero
// [RULE16] Indexed read loads both staged entries
// [RULE17] Indexed write stores both staged entries
// [RULE18] Reserved bits read zero, ignore writes
`timescale 1ns/10ps
`include "atab_regs.vh"
module atab_top #(
  parameter BIN_AW            = 4,
  parameter AGE_PERIOD_CYCLES = 1000000
) (
  input  wire                   mclk_in,
  input  wire                   rst_b_in,
  input  wire                   psel_in,
  input  wire                   penable_in,
  input  wire                   pwrite_in,
  input  wire [7:0]             paddr_in,
  input  wire [31:0]            pwdata_in,
  output reg                    pready_out,
  output reg  [31:0]            prdata_out,
  output reg                    pslverr_out,
  input  wire                   learn_req_in,
  input  wire [BIN_AW-1:0]      learn_bin_in,
  input  wire [`ATAB_MAC_W-1:0] learn_mac_in,
  input  wire [`ATAB_VID_W-1:0] learn_vid_in,
  input  wire [4:0]             learn_port_in,
  output reg                    learn_ready_out
);
  localparam [3:0] ST_CLEAR = 4'h1;
  localparam [3:0] ST_IDLE  = 4'h2;
  localparam [3:0] ST_WALK  = 4'h4;
  localparam [3:0] ST_AGE   = 4'h8;
  localparam [BIN_AW-1:0] BIN_LAST = {BIN_AW{1'b1}};
  localparam [BIN_AW-1:0] BIN_ONE  = 1;

  reg rst_meta_reg;
  reg rst_core_b_reg;
  reg [3:0] state_reg;
  reg [`ATAB_MAC_W-1:0] a_mac_reg;
  reg [`ATAB_VID_W-1:0] a_vid_reg;
  reg [`ATAB_FWD_W-1:0] a_fwd_reg;
  reg [`ATAB_MAC_W-1:0] b_mac_reg;
  reg [`ATAB_VID_W-1:0] b_vid_reg;
  reg [`ATAB_FWD_W-1:0] b_fwd_reg;
  reg [BIN_AW-1:0]      index_reg;
  reg                   cmd_rd_reg;
  reg                   cmd_wr_reg;
  reg                   start_reg;
  reg                   hit_reg;
  reg [`ATAB_ENT_W-1:0] r0_reg;
  reg [`ATAB_ENT_W-1:0] r1_reg;
  reg [BIN_AW-1:0]      walk_ptr_reg;
  reg                   walk_last_reg;
  reg [BIN_AW-1:0]      sweep_ptr_reg;
  reg                   age_pend_reg;
  reg [BIN_AW-1:0]      l_bin_reg;
  reg [`ATAB_MAC_W-1:0] l_mac_reg;
  reg [`ATAB_VID_W-1:0] l_vid_reg;
  reg [4:0]             l_port_reg;

  wire [`ATAB_ENT_W-1:0] rd0;
  wire [`ATAB_ENT_W-1:0] rd1;
  wire                   age_tick;
  reg  [BIN_AW-1:0]      rbin;
  reg                    we0;
  reg                    we1;
  reg  [`ATAB_ENT_W-1:0] wd0;
  reg  [`ATAB_ENT_W-1:0] wd1;
  reg  [31:0]            rd_mux;
  reg                    rd_hit;

  // Occupied for the walk: valid and age clear
  function hit_ok;
    input [`ATAB_ENT_W-1:0] e;
    begin
      hit_ok = e[`ATAB_FWD_VALID] & ~e[`ATAB_FWD_AGE];
    end
  endfunction

  // Same station already stored
  function key_eq;
    input [`ATAB_ENT_W-1:0] e;
    input [`ATAB_MAC_W-1:0] mac;
    input [`ATAB_VID_W-1:0] vid;
    begin
      key_eq = e[`ATAB_FWD_VALID] & (e[`ATAB_E_MAC] == mac) & (e[`ATAB_E_VID] == vid);
    end
  endfunction

  // Refresh an entry on access: age set on all, port kept on static and multicast ones
  function [`ATAB_ENT_W-1:0] touch;
    input [`ATAB_ENT_W-1:0] e;
    input [4:0]             port;
    begin
      touch = e;
      touch[`ATAB_FWD_AGE] = 1'b1;
      if (!e[`ATAB_FWD_STATIC] && !e[`ATAB_E_MCAST]) begin
        touch[`ATAB_FWD_PORT] = port;
      end
    end
  endfunction

  // One aging step on an entry
  function [`ATAB_ENT_W-1:0] age_step;
    input [`ATAB_ENT_W-1:0] e;
    begin
      age_step = e;
      if (e[`ATAB_FWD_VALID] && !e[`ATAB_FWD_STATIC]) begin
        if (e[`ATAB_FWD_AGE]) begin
          age_step[`ATAB_FWD_AGE] = 1'b0;
        end else begin
          age_step[`ATAB_FWD_VALID] = 1'b0;
        end
      end
    end
  endfunction

  // Role view of a forwarding word
  function [31:0] fwd_view;
    input                   mcast;
    input [`ATAB_FWD_W-1:0] f;
    begin
      fwd_view = `ATAB_RST_32;
      if (mcast) begin
        fwd_view[`ATAB_DEC_MCAST] = 1'b1;
        fwd_view[`ATAB_DEC_MAP] = {f[`ATAB_FWD_MAPHI], f[`ATAB_FWD_PORT], f[`ATAB_FWD_STATIC]};
      end else begin
        fwd_view[`ATAB_DEC_PORT]   = f[`ATAB_FWD_PORT];
        fwd_view[`ATAB_DEC_STATIC] = f[`ATAB_FWD_STATIC];
      end
    end
  endfunction

  // Reset release through two flops
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_reg   <= 1'b0;
      rst_core_b_reg <= 1'b0;
    end else begin
      rst_meta_reg   <= 1'b1;
      rst_core_b_reg <= rst_meta_reg;
    end
  end

  atab_bin_store #(
    .BIN_AW (BIN_AW),
    .ENT_W  (`ATAB_ENT_W)
  ) u_store (
    .clk_in  (mclk_in),
    .rbin_in (rbin),
    .rd0_out (rd0),
    .rd1_out (rd1),
    .wbin_in (rbin),
    .we0_in  (we0),
    .we1_in  (we1),
    .wd0_in  (wd0),
    .wd1_in  (wd1)
  );

  atab_age_tick #(
    .PERIOD (AGE_PERIOD_CYCLES),
    .CNT_W  (32)
  ) u_age (
    .clk_in   (mclk_in),
    .rst_b_in (rst_core_b_reg),
    .tick_out (age_tick)
  );

  wire apb_first = psel_in & penable_in & ~pready_out;
  wire apb_done  = psel_in & penable_in & pready_out;
  wire wr_done   = apb_done & pwrite_in;
  wire rd_done   = apb_done & ~pwrite_in;
  wire not_clr   = ~state_reg[0];
  wire serve_cmd = not_clr & (cmd_rd_reg | cmd_wr_reg);
  wire serve_lrn = not_clr & ~serve_cmd & ~learn_ready_out;
  wire step      = ~serve_cmd & ~serve_lrn;

  // Table port: post-reset clear first, then commands, then learning, then the state's sweep
  always @* begin
    rbin = state_reg[2] ? walk_ptr_reg : sweep_ptr_reg;
    we0  = 1'b0;
    we1  = 1'b0;
    wd0  = rd0;
    wd1  = rd1;
    if (state_reg[0]) begin
      we0 = 1'b1;
      we1 = 1'b1;
      wd0 = `ATAB_RST_ENT;
      wd1 = `ATAB_RST_ENT;
    end else if (serve_cmd) begin
      rbin = index_reg;
      // [RULE17] whole bin overwrite
      if (cmd_wr_reg) begin
        we0 = 1'b1;
        we1 = 1'b1;
        wd0 = {a_vid_reg, a_mac_reg, a_fwd_reg};
        wd1 = {b_vid_reg, b_mac_reg, b_fwd_reg};
      end
    end else if (serve_lrn) begin
      rbin = l_bin_reg;
      // [RULE7] mark accessed on a hit
      if (key_eq(rd0, l_mac_reg, l_vid_reg)) begin
        we0 = 1'b1;
        wd0 = touch(rd0, l_port_reg);
      end else if (key_eq(rd1, l_mac_reg, l_vid_reg)) begin
        we1 = 1'b1;
        wd1 = touch(rd1, l_port_reg);
      // [RULE8] free slot only
      end else if (!rd0[`ATAB_FWD_VALID] && !rd0[`ATAB_FWD_STATIC]) begin
        we0 = 1'b1;
        wd0 = {l_vid_reg, l_mac_reg, 11'h0, l_port_reg, `ATAB_LRN_FLAGS};
      end else if (!rd1[`ATAB_FWD_VALID] && !rd1[`ATAB_FWD_STATIC]) begin
        we1 = 1'b1;
        wd1 = {l_vid_reg, l_mac_reg, 11'h0, l_port_reg, `ATAB_LRN_FLAGS};
      end
    end else if (state_reg[3]) begin
      // [RULE6] static skipped by aging
      we0 = 1'b1;
      we1 = 1'b1;
      wd0 = age_step(rd0);
      wd1 = age_step(rd1);
    end
  end

  // Read data mux; reserved bits come back as zero
  always @* begin
    rd_hit = 1'b1;
    case (paddr_in)
      `ATAB_OFF_A_MACLO: rd_mux = a_mac_reg[`ATAB_MAC_LO];
      `ATAB_OFF_A_MACHI: rd_mux = {4'h0, a_vid_reg, a_mac_reg[`ATAB_MAC_HI]};
      `ATAB_OFF_A_FWD:   rd_mux = {10'h0, a_fwd_reg};
      // [RULE2] station mac of entry b
      `ATAB_OFF_B_MACLO: rd_mux = b_mac_reg[`ATAB_MAC_LO];
      // [RULE1] VLAN ID beside mac
      `ATAB_OFF_B_MACHI: rd_mux = {4'h0, b_vid_reg, b_mac_reg[`ATAB_MAC_HI]};
      // [RULE18] reserved read zero
      `ATAB_OFF_B_FWD:   rd_mux = {10'h0, b_fwd_reg};
      // [RULE3] [RULE4] [RULE5] role decode
      `ATAB_OFF_B_DEC:   rd_mux = fwd_view(b_mac_reg[`ATAB_MCAST_BIT], b_fwd_reg);
      `ATAB_OFF_CTL:     rd_mux = {24'h0, start_reg, 6'h0, hit_reg};
      `ATAB_OFF_INDEX:   rd_mux = {{(32-BIN_AW){1'b0}}, index_reg};
      `ATAB_OFF_CMD:     rd_mux = {30'h0, cmd_wr_reg, cmd_rd_reg};
      `ATAB_OFF_R0_LO:   rd_mux = r0_reg[`ATAB_E_MACLO];
      `ATAB_OFF_R0_VID:  rd_mux = {4'h0, r0_reg[`ATAB_E_VID], r0_reg[`ATAB_E_MACHI]};
      `ATAB_OFF_R0_FWD:  rd_mux = {10'h0, r0_reg[`ATAB_E_FWD]};
      `ATAB_OFF_R1_LO:   rd_mux = r1_reg[`ATAB_E_MACLO];
      `ATAB_OFF_R1_VID:  rd_mux = {4'h0, r1_reg[`ATAB_E_VID], r1_reg[`ATAB_E_MACHI]};
      `ATAB_OFF_R1_FWD:  rd_mux = {10'h0, r1_reg[`ATAB_E_FWD]};
      default: begin
        rd_mux = `ATAB_RST_32;
        rd_hit = 1'b0;
      end
    endcase
  end

  // APB handshake: one wait state, answer registered
  always @(posedge mclk_in or negedge rst_core_b_reg) begin
    if (!rst_core_b_reg) begin
      pready_out  <= 1'b0;
      prdata_out  <= `ATAB_RST_32;
      pslverr_out <= 1'b0;
    end else if (apb_first) begin
      pready_out  <= 1'b1;
      prdata_out  <= pwrite_in ? `ATAB_RST_32 : rd_mux;
      pslverr_out <= ~rd_hit;
    end else begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

  // Engine and register file; software writes come last so they win
  always @(posedge mclk_in or negedge rst_core_b_reg) begin
    if (!rst_core_b_reg) begin
      state_reg <= ST_CLEAR;
      a_mac_reg <= `ATAB_RST_MAC;
      a_vid_reg <= `ATAB_RST_VID;
      a_fwd_reg <= `ATAB_RST_FWD;
      b_mac_reg <= `ATAB_RST_MAC;
      b_vid_reg <= `ATAB_RST_VID;
      b_fwd_reg <= `ATAB_RST_FWD;
      index_reg <= {BIN_AW{1'b0}};
      cmd_rd_reg <= 1'b0;
      cmd_wr_reg <= 1'b0;
      start_reg <= 1'b0;
      hit_reg <= 1'b0;
      r0_reg <= `ATAB_RST_ENT;
      r1_reg <= `ATAB_RST_ENT;
      walk_ptr_reg <= {BIN_AW{1'b0}};
      walk_last_reg <= 1'b0;
      sweep_ptr_reg <= {BIN_AW{1'b0}};
      age_pend_reg <= 1'b0;
      l_bin_reg <= {BIN_AW{1'b0}};
      l_mac_reg <= `ATAB_RST_MAC;
      l_vid_reg <= `ATAB_RST_VID;
      l_port_reg <= 5'h0;
      learn_ready_out <= 1'b1;
    end else begin
      // Tick kept until the sweep starts; a new tick wins
      if (age_tick) begin
        age_pend_reg <= 1'b1;
      end
      if (serve_lrn) begin
        learn_ready_out <= 1'b1;
      end else if (learn_req_in && learn_ready_out) begin
        learn_ready_out <= 1'b0;
        l_bin_reg  <= learn_bin_in;
        l_mac_reg  <= learn_mac_in;
        l_vid_reg  <= learn_vid_in;
        l_port_reg <= learn_port_in;
      end
      if (serve_cmd && cmd_wr_reg) begin
        cmd_wr_reg <= 1'b0;
      end else if (serve_cmd) begin
        // [RULE16] bin into both stages
        cmd_rd_reg <= 1'b0;
        {a_vid_reg, a_mac_reg, a_fwd_reg} <= rd0;
        {b_vid_reg, b_mac_reg, b_fwd_reg} <= rd1;
      end
      if (step) begin
        case (state_reg)
          ST_CLEAR: begin
            sweep_ptr_reg <= sweep_ptr_reg + BIN_ONE;
            if (sweep_ptr_reg == BIN_LAST) begin
              state_reg <= ST_IDLE;
            end
          end
          ST_IDLE: begin
            if (age_pend_reg && !age_tick) begin
              age_pend_reg <= 1'b0;
              state_reg <= ST_AGE;
            end else if (start_reg) begin
              state_reg <= ST_WALK;
            end
          end
          ST_AGE: begin
            sweep_ptr_reg <= sweep_ptr_reg + BIN_ONE;
            if (sweep_ptr_reg == BIN_LAST) begin
              state_reg <= start_reg ? ST_WALK : ST_IDLE;
            end
          end
          ST_WALK: begin
            if (age_pend_reg) begin
              state_reg <= ST_IDLE;
            end else if (!hit_reg && walk_last_reg) begin
              // [RULE10] walk over, self-clear
              start_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end else if (!hit_reg) begin
              // [RULE9] stage occupied entries
              if (hit_ok(rd0) || hit_ok(rd1)) begin
                r0_reg <= hit_ok(rd0) ? rd0 : `ATAB_RST_ENT;
                r1_reg <= hit_ok(rd1) ? rd1 : `ATAB_RST_ENT;
                // [RULE11] result waiting
                hit_reg <= 1'b1;
              end
              walk_ptr_reg <= walk_ptr_reg + BIN_ONE;
              walk_last_reg <= (walk_ptr_reg == BIN_LAST);
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
      // [RULE12] [RULE14] entry zero read resumes, clears results
      // [RULE13] vid result reads fall through untouched
      // Gated by the flag so a hit staged in this cycle is not lost
      if (rd_done && hit_reg && paddr_in == `ATAB_OFF_R0_FWD) begin
        hit_reg <= 1'b0;
        r0_reg <= `ATAB_RST_ENT;
        r1_reg <= `ATAB_RST_ENT;
      end
      if (wr_done) begin
        // [RULE18] only defined fields stored
        case (paddr_in)
          `ATAB_OFF_A_MACLO: a_mac_reg[`ATAB_MAC_LO] <= pwdata_in;
          `ATAB_OFF_A_MACHI: begin
            a_mac_reg[`ATAB_MAC_HI] <= pwdata_in[`ATAB_W_MACHI];
            a_vid_reg <= pwdata_in[`ATAB_W_VID];
          end
          `ATAB_OFF_A_FWD: a_fwd_reg <= pwdata_in[`ATAB_E_FWD];
          `ATAB_OFF_B_MACLO: b_mac_reg[`ATAB_MAC_LO] <= pwdata_in;
          `ATAB_OFF_B_MACHI: begin
            b_mac_reg[`ATAB_MAC_HI] <= pwdata_in[`ATAB_W_MACHI];
            b_vid_reg <= pwdata_in[`ATAB_W_VID];
          end
          `ATAB_OFF_B_FWD: b_fwd_reg <= pwdata_in[`ATAB_E_FWD];
          `ATAB_OFF_CTL: begin
            // Running walk cannot be restarted or aborted
            if (pwdata_in[`ATAB_CTL_START] && !start_reg) begin
              start_reg <= 1'b1;
              hit_reg <= 1'b0;
              walk_ptr_reg <= {BIN_AW{1'b0}};
              walk_last_reg <= 1'b0;
            end
          end
          `ATAB_OFF_INDEX: index_reg <= pwdata_in[BIN_AW-1:0];
          `ATAB_OFF_CMD: begin
            if (pwdata_in[`ATAB_CMD_RD]) begin
              cmd_rd_reg <= 1'b1;
            end
            if (pwdata_in[`ATAB_CMD_WR]) begin
              cmd_wr_reg <= 1'b1;
            end
          end
          default: begin
            index_reg <= index_reg;
          end
        endcase
      end
    end
  end
endmodule
